// ==== hdl/accel_ctrl_irq_regs.sv ====
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
// Notes on behaviour
// - A global enable, set or cleared by software, forces the interrupt low while cleared.
// - The interrupt logic exists only when the block has a launch request port.
// - Two interrupt sources: bit 0 completion, bit 1 input accept.
// - Writing the enable-set register turns on sources whose mask bit is one.
// - Writing the enable-clear register turns off sources whose mask bit is one.
// - Writing the status register toggles bits whose mask bit is one.
// - Reading the enable register shows one bit per enabled source.
// - Reading the status register shows one bit per triggered source.
// - Array elements narrower than 16 bits are packed several to a word.
// - Array elements wider than 32 bits span consecutive word addresses.
// - Arrays take 32-bit word writes and reads at an offset from their base.
// - Arrays also take byte-wide writes at an offset from their base; reads always return the whole 32-bit word.
// - Each scalar output argument has a readable value register.
// - An output argument's valid flag is readable.
// - An input argument's acknowledge flag is readable.
// - With auto-restart on, the launch request reasserts when completion occurs.
module accel_ctrl_irq_regs
    import accel_regs_pkg::*;
#(
    parameter bit HAS_LAUNCH = 1'b1,
    parameter int ARR8_WORDS = 16,
    parameter int ARR64_ELEMS = 8,
    parameter int RES_WIDTH = 32
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    // Kernel side
    input wire kernel_status_type kstat_i,
    input wire logic [RES_WIDTH-1:0] result_i,
    output logic launch_request_o,
    output logic irq_o
);
    localparam int A8W = $clog2(ARR8_WORDS);
    localparam int A64W = $clog2(2 * ARR64_ELEMS);

    initial
    begin
        if (RES_WIDTH < 1 || RES_WIDTH > 32) $error("RES_WIDTH must be 1..32");
        if (ARR8_WORDS < 2 || ARR64_ELEMS < 1) $error("array sizes too small");
        if (4 * ARR8_WORDS > 1024 || 8 * ARR64_ELEMS > 1024) $error("array too large for window");
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    typedef enum {ST_IDLE, ST_WAIT} bus_state_type;
    bus_state_type bus_state_r;
    logic setup_w;
    logic access_w;
    logic wr_w;
    logic rd_w;
    logic in_arr8_w;
    logic in_arr64_w;
    logic regs_hit_w;

    // Word index within a window
    function automatic logic [9:0] word_idx(input logic [11:0] a);
        word_idx = a[11:2] & 10'h0FF;
    endfunction

    assign setup_w = psel_i && !penable_i;
    assign in_arr8_w = (paddr_i[11:10] == OFS_ARR8_BASE[11:10]) && (word_idx(paddr_i) < 10'(ARR8_WORDS));
    assign in_arr64_w = (paddr_i[11:10] == OFS_ARR64_BASE[11:10]) && (word_idx(paddr_i) < 10'(2 * ARR64_ELEMS));
    assign regs_hit_w = (paddr_i == OFS_CTRL) || (paddr_i == OFS_GIE) || (paddr_i == OFS_IER_SET)
        || (paddr_i == OFS_IER_CLR) || (paddr_i == OFS_ISR) || (paddr_i == OFS_IER)
        || (paddr_i == OFS_RES_VAL) || (paddr_i == OFS_RES_FLAG) || (paddr_i == OFS_ARG_FLAG);

    // Arrays need one wait cycle for registered memory reads
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            bus_state_r <= ST_IDLE;
        else
        begin
            unique case (bus_state_r)
                ST_IDLE: if (psel_i && penable_i && (in_arr8_w || in_arr64_w) && !pwrite_i) bus_state_r <= ST_WAIT;
                ST_WAIT: bus_state_r <= ST_IDLE;
            endcase
        end
    end

    assign pready_o = !(psel_i && penable_i && (in_arr8_w || in_arr64_w) && !pwrite_i) || bus_state_r == ST_WAIT;
    assign access_w = psel_i && penable_i && pready_o;
    assign wr_w = access_w && pwrite_i;
    assign rd_w = access_w && !pwrite_i;
    assign pslverr_o = access_w && !regs_hit_w && !in_arr8_w && !in_arr64_w;

    ////////////////////////////////////////////////////////////////////////
    // Control: launch request and auto-restart

    logic auto_restart_r;
    logic launch_r;
    logic ctrl_wr_w;

    assign ctrl_wr_w = wr_w && paddr_i == OFS_CTRL && pstrb_i[0];

    // Auto-restart flag
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            auto_restart_r <= 1'b0;
        else if (ctrl_wr_w)
            auto_restart_r <= pwdata_i[CTRL_AUTO_BIT];
    end

    // Launch request held until the kernel accepts its inputs
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            launch_r <= 1'b0;
        else if (ctrl_wr_w && pwdata_i[CTRL_LAUNCH_BIT])
            launch_r <= 1'b1;
        else if (auto_restart_r && kstat_i.completion_event)
            launch_r <= 1'b1;
        else if (kstat_i.input_accept_event)
            launch_r <= 1'b0;
    end

    assign launch_request_o = HAS_LAUNCH ? launch_r : 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt logic

    logic gie_w;
    logic [NUM_SRC-1:0] ier_w;
    logic [NUM_SRC-1:0] isr_w;
    logic [NUM_SRC-1:0] events_w;

    // Source mapping
    assign events_w[SRC_DONE] = kstat_i.completion_event;
    assign events_w[SRC_ACCEPT] = kstat_i.input_accept_event;

    // Built only with a launch port
    generate
        if (HAS_LAUNCH)
        begin : g_irq
            irq_unit u_irq (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .gie_wr_i(wr_w && paddr_i == OFS_GIE && pstrb_i[0]),
                .gie_val_i(pwdata_i[0]),
                .ier_set_i(wr_w && paddr_i == OFS_IER_SET && pstrb_i[0]),
                .ier_clr_i(wr_w && paddr_i == OFS_IER_CLR && pstrb_i[0]),
                .isr_wr_i(wr_w && paddr_i == OFS_ISR && pstrb_i[0]),
                .mask_i(pwdata_i[NUM_SRC-1:0]),
                .event_i(events_w),
                .gie_o(gie_w),
                .ier_o(ier_w),
                .isr_o(isr_w),
                .irq_o(irq_o)
            );
        end
        else
        begin : g_noirq
            assign gie_w = 1'b0;
            assign ier_w = '0;
            assign isr_w = '0;
            assign irq_o = 1'b0;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Argument arrays

    logic [31:0] arr8_rd_w;
    logic [31:0] arr64_rd_w;

    // 8-bit elements packed four per word, byte strobes honoured
    arg_array_mem #(.DEPTH(ARR8_WORDS), .AW(A8W)) u_arr8 (
        .clk_i(clk_i),
        .addr_i(paddr_i[A8W+1:2]),
        .wstrb_i((wr_w && in_arr8_w) ? pstrb_i : 4'h0),
        .wdata_i(pwdata_i),
        .rdata_o(arr8_rd_w)
    );

    // 64-bit elements: low word at even index, high word at odd index
    arg_array_mem #(.DEPTH(2 * ARR64_ELEMS), .AW(A64W)) u_arr64 (
        .clk_i(clk_i),
        .addr_i(paddr_i[A64W+1:2]),
        .wstrb_i((wr_w && in_arr64_w) ? pstrb_i : 4'h0),
        .wdata_i(pwdata_i),
        .rdata_o(arr64_rd_w)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read data

    logic [31:0] rd_nxt;
    logic rd_load_w;

    // Register reads load at the setup edge; array reads load again once the memory word has arrived,
    // so the data already stands in the cycle in which pready is high
    assign rd_load_w = psel_i && !pwrite_i && (setup_w || (penable_i && !pready_o));

    // Register read mux
    always_comb
    begin
        rd_nxt = UNMAPPED_DATA;
        if (in_arr8_w)
            rd_nxt = arr8_rd_w;
        else if (in_arr64_w)
            rd_nxt = arr64_rd_w;
        else if (paddr_i == OFS_CTRL)
            rd_nxt = {30'h0, auto_restart_r, launch_r};
        else if (paddr_i == OFS_GIE)
            rd_nxt = {31'h0, gie_w};
        else if (paddr_i == OFS_IER)
            rd_nxt = {30'h0, ier_w};
        else if (paddr_i == OFS_ISR)
            rd_nxt = {30'h0, isr_w};
        else if (paddr_i == OFS_RES_VAL)
            rd_nxt = 32'(result_i);
        else if (paddr_i == OFS_RES_FLAG)
            rd_nxt = {31'h0, kstat_i.argument_valid_flag};
        else if (paddr_i == OFS_ARG_FLAG)
            rd_nxt = {31'h0, kstat_i.argument_ack_flag};
    end

    // Read data registered ahead of the completing edge and held through it
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            prdata_o <= 32'h0000_0000;
        else if (rd_load_w)
            prdata_o <= rd_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Interrupt output against its enables and status
    gie_gates_irq_a: assert property (!gie_w |-> !irq_o) else $error("irq while global off");
    irq_cause_a: assert property (irq_o == (gie_w && |(ier_w & isr_w))) else $error("irq mismatch");

    // Source enables follow the set and clear masks and nothing else
    ier_set_a: assert property (wr_w && paddr_i == OFS_IER_SET && pstrb_i[0] && HAS_LAUNCH
        |=> ier_w == ($past(ier_w) | $past(pwdata_i[1:0]))) else $error("enable set wrong");
    ier_clr_a: assert property (wr_w && paddr_i == OFS_IER_CLR && pstrb_i[0] && HAS_LAUNCH
        |=> ier_w == ($past(ier_w) & ~$past(pwdata_i[1:0]))) else $error("enable clear wrong");
    ier_hold_a: assert property (!(wr_w && pstrb_i[0])
        || (paddr_i != OFS_IER_SET && paddr_i != OFS_IER_CLR)
        |=> $stable(ier_w)) else $error("enable changed unasked");

    // Status toggles by mask; events set their own bit
    isr_toggle_a: assert property (wr_w && paddr_i == OFS_ISR && pstrb_i[0] && HAS_LAUNCH && !(|events_w)
        |=> isr_w == ($past(isr_w) ^ $past(pwdata_i[1:0]))) else $error("status toggle wrong");
    done_sets_a: assert property (kstat_i.completion_event && HAS_LAUNCH |=> isr_w[SRC_DONE])
        else $error("done not latched");
    accept_sets_a: assert property (kstat_i.input_accept_event && HAS_LAUNCH |=> isr_w[SRC_ACCEPT])
        else $error("accept not latched");

    // With auto-restart on, the launch request comes back by itself after completion
    auto_restart_a: assert property (auto_restart_r && kstat_i.completion_event && !ctrl_wr_w
        |=> launch_r) else $error("no auto restart");

    // Read data stands in the completing cycle and shows the value of the setup cycle
    ier_read_a: assert property (rd_w && paddr_i == OFS_IER |-> prdata_o == {30'h0, $past(ier_w)})
        else $error("enable readback wrong");
    isr_read_a: assert property (rd_w && paddr_i == OFS_ISR |-> prdata_o == {30'h0, $past(isr_w)})
        else $error("status readback wrong");
    result_read_a: assert property (rd_w && paddr_i == OFS_RES_VAL |-> prdata_o == 32'($past(result_i)))
        else $error("result readback wrong");
    valid_read_a: assert property (rd_w && paddr_i == OFS_RES_FLAG
        |-> prdata_o[0] == $past(kstat_i.argument_valid_flag)) else $error("valid readback wrong");
    ack_read_a: assert property (rd_w && paddr_i == OFS_ARG_FLAG
        |-> prdata_o[0] == $past(kstat_i.argument_ack_flag)) else $error("ack readback wrong");

    // Bus timing: writes finish at once, 8-bit array reads take one wait cycle
    write_ready_a: assert property (psel_i && penable_i && pwrite_i |-> pready_o)
        else $error("write stalled");
    arr_wait_a: assert property (psel_i && penable_i && !pwrite_i && in_arr8_w && bus_state_r == ST_IDLE
        |-> !pready_o ##1 pready_o) else $error("array read timing");

    // Main scenarios
    irq_seen_c: cover property (irq_o);
    arr_read_c: cover property (rd_w && in_arr64_w);
    restart_c: cover property (auto_restart_r && kstat_i.completion_event);
    isr_toggle_c: cover property (wr_w && paddr_i == OFS_ISR && pstrb_i[0]);
    byte_write_c: cover property (wr_w && in_arr8_w && pstrb_i != 4'hF);
endmodule

// ==== common/accel_regs_pkg.sv ====
package accel_regs_pkg;
    // Register byte offsets
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_GIE = 12'h004;
    localparam logic [11:0] OFS_IER_SET = 12'h008;
    localparam logic [11:0] OFS_IER_CLR = 12'h00C;
    localparam logic [11:0] OFS_ISR = 12'h010;
    localparam logic [11:0] OFS_IER = 12'h014;
    localparam logic [11:0] OFS_RES_VAL = 12'h018;
    localparam logic [11:0] OFS_RES_FLAG = 12'h01C;
    localparam logic [11:0] OFS_ARG_FLAG = 12'h020;
    localparam logic [11:0] OFS_ARR8_BASE = 12'h400;
    localparam logic [11:0] OFS_ARR64_BASE = 12'h800;
    // Control register fields
    localparam int CTRL_LAUNCH_BIT = 0;
    localparam int CTRL_AUTO_BIT = 1;
    // Interrupt source positions
    localparam int SRC_DONE = 0;
    localparam int SRC_ACCEPT = 1;
    localparam int NUM_SRC = 2;
    // Reset values and unmapped read data
    localparam logic [NUM_SRC-1:0] IER_RESET = 2'h0;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
    // Status flags of the attached kernel, carried together
    typedef struct packed {
        logic completion_event;
        logic input_accept_event;
        logic argument_valid_flag;
        logic argument_ack_flag;
    } kernel_status_type;
endpackage

// ==== hdl/arg_array_mem.sv ====
`timescale 1ns/100ps
// Word-wide array store with byte write enables and registered read data
module arg_array_mem #(
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    // Clock
    input wire logic clk_i,
    // Access port
    input wire logic [AW-1:0] addr_i,
    input wire logic [3:0] wstrb_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] rdata_o
);
    logic [31:0] mem [DEPTH];

    initial
    begin
        if (DEPTH > (1 << AW)) $error("arg_array_mem: DEPTH exceeds address range");
    end

    // Byte-lane writes; read data registered
    always_ff @(posedge clk_i)
    begin
        for (int b = 0; b < 4; b++)
        begin
            if (wstrb_i[b])
                mem[addr_i][8*b +: 8] <= wdata_i[8*b +: 8];
        end
        rdata_o <= mem[addr_i];
    end
endmodule

// ==== hdl/irq_unit.sv ====
`timescale 1ns/100ps
// Global and per-source interrupt enables and toggle-cleared status
module irq_unit
    import accel_regs_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Software controls
    input wire logic gie_wr_i,
    input wire logic gie_val_i,
    input wire logic ier_set_i,
    input wire logic ier_clr_i,
    input wire logic isr_wr_i,
    input wire logic [NUM_SRC-1:0] mask_i,
    // Events
    input wire logic [NUM_SRC-1:0] event_i,
    // State
    output logic gie_o,
    output logic [NUM_SRC-1:0] ier_o,
    output logic [NUM_SRC-1:0] isr_o,
    output logic irq_o
);
    // Global enable
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            gie_o <= 1'b0;
        else if (gie_wr_i)
            gie_o <= gie_val_i;
    end

    // Source enables: set and clear masks
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ier_o <= IER_RESET;
        else if (ier_set_i)
            ier_o <= ier_o | mask_i;
        else if (ier_clr_i)
            ier_o <= ier_o & ~mask_i;
    end

    // Status: toggle by mask, event set wins
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            isr_o <= '0;
        else
            isr_o <= (isr_wr_i ? (isr_o ^ mask_i) : isr_o) | event_i;
    end

    // Level interrupt
    assign irq_o = gie_o && |(ier_o & isr_o);
endmodule

// ==== verification/kernel_model.sv ====
`timescale 1ns/100ps
// Behavioural kernel: takes a launch, pulses accept, then pulses completion with a new result
module kernel_model
    import accel_regs_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Launch request from the register block, slow mode from the bench
    input wire logic launch_request_i,
    input wire logic slow_i,
    // Status back to the register block
    output kernel_status_type kstat_o,
    output logic [31:0] result_o
);
    int cnt_r;
    // Job sequencer; slow mode stretches both latencies
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_r <= 0;
            kstat_o <= '0;
            result_o <= 32'h0000_0000;
        end
        else
        begin
            kstat_o.completion_event <= 1'b0;
            kstat_o.input_accept_event <= 1'b0;
            if (cnt_r != 0 || launch_request_i)
                cnt_r <= cnt_r + 1;
            if (cnt_r == 1)
            begin
                kstat_o.argument_valid_flag <= 1'b0;
                kstat_o.argument_ack_flag <= 1'b0;
            end
            if (cnt_r == (slow_i ? 6 : 3))
            begin
                kstat_o.input_accept_event <= 1'b1;
                kstat_o.argument_ack_flag <= 1'b1;
            end
            if (cnt_r == (slow_i ? 14 : 5))
            begin
                kstat_o.completion_event <= 1'b1;
                kstat_o.argument_valid_flag <= 1'b1;
                result_o <= result_o + 32'h1357_9BDF;
                cnt_r <= 0;
            end
        end
    end
endmodule

// ==== verification/accel_ctrl_irq_regs_tb_top.sv ====
`timescale 1ns/100ps
// Self-checking bench with a behavioural register model
module accel_ctrl_irq_regs_tb_top
    import accel_regs_pkg::*;
;
    logic clk_i, rst_n_i, psel, penable, pwrite, slow, pready, pslverr, launch, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, result, rd, lfsr;
    logic [3:0] pstrb;
    kernel_status_type kstat;
    logic gie_m = 1'b0;
    logic [1:0] ier_m = 2'h0;
    logic [1:0] isr_m = 2'h0;
    logic [31:0] mem_m [32];
    int n_done = 0;
    int n_acc = 0;
    int n_errors = 0;
    int checks_done = 0;

    accel_ctrl_irq_regs accel_ctrl_irq_regs_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .kstat_i(kstat), .result_i(result),
        .launch_request_o(launch), .irq_o(irq));
    kernel_model kernel_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .launch_request_i(launch),
        .slow_i(slow), .kstat_o(kstat), .result_o(result));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        print_verdict();
    end
    // Events seen by the design set the model status
    always @(posedge clk_i)
    begin
        if (kstat.completion_event === 1'b1)
        begin
            isr_m[0] <= 1'b1;
            n_done <= n_done + 1;
        end
        if (kstat.input_accept_event === 1'b1)
        begin
            isr_m[1] <= 1'b1;
            n_acc <= n_acc + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [11:0] aaddr(input int i);
        return (i < 16) ? OFS_ARR8_BASE + 12'(4 * i) : OFS_ARR64_BASE + 12'(4 * (i - 16));
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One APB transfer, begun right after a rising edge; the model follows writes at the completing edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] rdv, output logic errv);
        int n;
        int k;
        n = 0;
        k = a[11] ? 16 + a[5:2] : a[5:2];
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge clk_i);
            n++;
        end
        if (pready !== 1'b1)
            n_errors++;
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (wr && errv !== 1'b1)
            case (a)
                OFS_GIE: gie_m = d[0];
                OFS_IER_SET: ier_m = ier_m | d[1:0];
                OFS_IER_CLR: ier_m = ier_m & ~d[1:0];
                OFS_ISR: isr_m = isr_m ^ d[1:0];
                default: if (a >= OFS_ARR8_BASE) for (int b = 0; b < 4; b++) if (s[b]) mem_m[k][8*b +: 8] = d[8*b +: 8];
            endcase
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, 4'hF, r, e);
    endtask
    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, 4'h0, r, e);
        check(what, r, exp);
    endtask
    task automatic chk_irq();
        check("irq", {31'h0, irq}, {31'h0, gie_m & (|(ier_m & isr_m))});
    endtask
    task automatic wait_ev(input bit acc, input int target);
        int n;
        n = 0;
        while (((acc ? n_acc : n_done) < target) && n < 300)
        begin
            @(posedge clk_i);
            n++;
        end
        if ((acc ? n_acc : n_done) < target)
            n_errors++;
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        {rst_n_i, psel, penable, pwrite, slow} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        lfsr = 32'h0000_0004;
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (6) lfsr = lfsr_next(lfsr);
        // Reset values and an unmapped address
        rd_chk("gie", OFS_GIE, 32'h0000_0000);
        rd_chk("ier", OFS_IER, 32'h0000_0000);
        rd_chk("isr", OFS_ISR, 32'h0000_0000);
        rd_chk("argument_ack_flag", OFS_ARG_FLAG, 32'h0000_0000);
        apb(1'b1, 12'h3F0, 32'hFFFF_FFFF, 4'hF, rd, err);
        apb(1'b0, 12'h3F0, 32'h0000_0000, 4'h0, rd, err);
        check("unmapped_err", {31'h0, err}, 32'h0000_0001);
        check("unmapped_data", rd, UNMAPPED_DATA);
        // Random enable set and clear masks
        for (int i = 0; i < 8; i++)
        begin
            lfsr = lfsr_next(lfsr);
            wr(OFS_IER_SET, lfsr);
            lfsr = lfsr_next(lfsr);
            wr(OFS_IER_CLR, lfsr);
            rd_chk("ier", OFS_IER, {30'h0, ier_m});
        end
        // Slow job with the global enable off
        wr(OFS_IER_SET, 32'h0000_0003);
        slow <= 1'b1;
        wr(OFS_CTRL, 32'h0000_0001);
        wait_ev(1'b1, 1);
        rd_chk("isr_accept", OFS_ISR, {30'h0, isr_m});
        wait_ev(1'b0, 1);
        chk_irq();
        rd_chk("isr_done", OFS_ISR, {30'h0, isr_m});
        wr(OFS_GIE, 32'h0000_0001);
        chk_irq();
        wr(OFS_ISR, 32'h0000_0001);
        chk_irq();
        wr(OFS_IER_CLR, 32'h0000_0002);
        chk_irq();
        wr(OFS_ISR, 32'h0000_0003);
        rd_chk("isr_toggle", OFS_ISR, {30'h0, isr_m});
        chk_irq();
        wr(OFS_GIE, 32'h0000_0000);
        chk_irq();
        // Auto-restart, then readback of the result and flags
        slow <= 1'b0;
        wr(OFS_CTRL, 32'h0000_0003);
        wait_ev(1'b0, 2);
        check("launch_auto", {31'h0, launch}, 32'h0000_0001);
        wr(OFS_CTRL, 32'h0000_0000);
        repeat (40) @(posedge clk_i);
        check("launch_idle", {31'h0, launch}, 32'h0000_0000);
        rd_chk("result", OFS_RES_VAL, 32'(n_done) * 32'h1357_9BDF);
        rd_chk("res_valid", OFS_RES_FLAG, 32'h0000_0001);
        rd_chk("argument_ack_flag", OFS_ARG_FLAG, 32'h0000_0001);
        // Arrays: full words, then single bytes, then readback of all
        for (int i = 0; i < 32; i++)
        begin
            lfsr = lfsr_next(lfsr);
            apb(1'b1, aaddr(i), lfsr, 4'hF, rd, err);
        end
        for (int i = 0; i < 24; i++)
        begin
            lfsr = lfsr_next(lfsr);
            apb(1'b1, aaddr(lfsr[4:0]), lfsr, 4'h1 << lfsr[6:5], rd, err);
        end
        for (int i = 0; i < 32; i++)
            rd_chk("array", aaddr(i), mem_m[i]);
        print_verdict();
    end
endmodule
